// ### verilog/trip_logic_pkg.sv
package trip_logic_pkg;

  // auxiliary unit mask layout, one yes/no entry per unit
  localparam int AUX_EXT_W = 43;          // units fed from aux_trip_in
  localparam int AUX_W     = 44;          // plus the combined discordance entry
  localparam int AUX_THERMAL_BIT  = 0;
  localparam int AUX_OVEX_LSB     = 1;    // four overexcitation stages
  localparam int AUX_OPEN_PH_BIT  = 5;
  localparam int AUX_TOC_PH_LSB   = 6;
  localparam int AUX_IOC_PH_LSB   = 9;
  localparam int AUX_TOC_GND_LSB  = 12;
  localparam int AUX_IOC_GND_LSB  = 15;
  localparam int AUX_TOC_NEG_LSB  = 18;
  localparam int AUX_IOC_NEG_LSB  = 21;
  localparam int AUX_STUB_BIT     = 24;
  localparam int AUX_UNDERV_LSB   = 25;
  localparam int AUX_OVERV_LSB    = 28;
  localparam int AUX_GND_OV_LSB   = 31;
  localparam int AUX_UNDERF_LSB   = 33;
  localparam int AUX_OVERF_LSB    = 36;
  localparam int AUX_ROC_LSB      = 39;
  localparam int AUX_EXT_BIT      = 42;
  localparam int AUX_DISC_BIT     = 43;

  // units that trip without the fault detector: thermal, overexcitation,
  // voltage, frequency and pole discordance
  localparam logic [AUX_W-1:0] DET_EXEMPT  = 44'hBFFFE00001F;
  localparam logic [AUX_W-1:0] MASK_RESET  = 44'h00000000000;

  // bit positions inside the synchroniser vector
  localparam int SYNC_W      = 64;
  localparam int SB_DISC1    = 43;
  localparam int SB_DISC2    = 44;
  localparam int SB_REC1     = 45;
  localparam int SB_REC2     = 46;
  localparam int SB_EXT_LSB  = 47;        // poles a, b, c
  localparam int SB_EXT_3PH  = 50;
  localparam int SB_PROG     = 51;
  localparam int SB_GBLK     = 52;
  localparam int SB_BLK_LSB  = 53;        // poles a, b, c
  localparam int SB_DET      = 56;
  localparam int SB_READY    = 57;
  localparam int SB_FPH_LSB  = 58;        // faulted phase a, b, c
  localparam int SB_CZ_LSB   = 61;        // current zero a, b, c

endpackage : trip_logic_pkg

// ### verilog/pole_trip_logic.sv
`timescale 1ns/10ps
module pole_trip_logic (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic trip_cmd,
  input  wire logic three_phase,
  input  wire logic phase_sel,
  input  wire logic pole_block,
  input  wire logic ext_pole,
  input  wire logic src_live,
  input  wire logic det_clear,
  input  wire logic current_zero,
  output logic      latch_q,
  output logic      pole_trip_q
);

  logic single_q;
  logic single_d;
  logic latch_d;
  wire  set_w;
  wire  release_w;

  //////////////////////////////////////////////////////////////////////////
  // latch set and release terms
  assign set_w     = trip_cmd & ~pole_block & (three_phase | phase_sel);
  // current zero only matters for single-phase trips
  assign release_w = ~src_live & (current_zero | ~single_q) & det_clear
                     & pole_block;
  assign latch_d   = set_w | (latch_q & ~release_w);
  assign single_d  = set_w ? ~three_phase : single_q;

  // external pole trip bypasses latch and block, drops with its input
  always_ff @(posedge clk) begin
    if (reset) begin
      latch_q     <= 1'b0;
      single_q    <= 1'b0;
      pole_trip_q <= 1'b0;
    end else begin
      latch_q     <= latch_d;
      single_q    <= single_d;
      pole_trip_q <= latch_d | ext_pole;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  chk_pole_block_set: assert property (@(posedge clk) disable iff (reset)
    $rose(latch_q) |-> $past(!pole_block))
    else $error("pole latch set while pole blocked");

  chk_latch_holds: assert property (@(posedge clk) disable iff (reset)
    (latch_q && !release_w) |=> latch_q)
    else $error("pole latch dropped without release");

  chk_latch_release: assert property (@(posedge clk) disable iff (reset)
    (latch_q && release_w && !set_w) |=> !latch_q)
    else $error("pole latch failed to release");

endmodule : pole_trip_logic

// ### verilog/breaker_trip_logic.sv
`timescale 1ns/10ps
module breaker_trip_logic (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic [2:0] pole_trip,
  input  wire logic three_phase,
  input  wire logic disc_brk1,
  input  wire logic disc_brk2,
  input  wire logic rec_brk1,
  input  wire logic rec_brk2,
  output logic      trip_q,
  output logic      three_phase_trip_q,
  output logic      disc_combined_q,
  output logic      rec_combined_q
);

  wire any_pole_w;
  wire disc_w;
  wire rec_w;

  //////////////////////////////////////////////////////////////////////////
  // breaker level combination
  assign any_pole_w = |pole_trip;
  assign disc_w     = disc_brk1 | disc_brk2;
  assign rec_w      = rec_brk1 | rec_brk2;

  always_ff @(posedge clk) begin
    if (reset) begin
      trip_q             <= 1'b0;
      three_phase_trip_q <= 1'b0;
      disc_combined_q    <= 1'b0;
      rec_combined_q     <= 1'b0;
    end else begin
      trip_q             <= any_pole_w;
      three_phase_trip_q <= any_pole_w & three_phase;
      disc_combined_q    <= disc_w;
      rec_combined_q     <= rec_w;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  chk_breaker_trip: assert property (@(posedge clk) disable iff (reset)
    pole_trip[0] |=> trip_q)
    else $error("pole a trip did not reach breaker trip");

  chk_three_phase_sub: assert property (@(posedge clk) disable iff (reset)
    three_phase_trip_q |-> trip_q)
    else $error("three phase trip without general trip");

  chk_disc_or: assert property (@(posedge clk) disable iff (reset)
    (disc_brk1 || disc_brk2) |=> disc_combined_q)
    else $error("combined discordance missed one breaker");

endmodule : breaker_trip_logic

// ### verilog/single_three_phase_trip_logic.sv
`timescale 1ns/10ps
module single_three_phase_trip_logic
  import trip_logic_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic [AUX_EXT_W-1:0] aux_trip_in,
  input  wire logic [AUX_W-1:0]     aux_mask_in,
  input  wire logic                 aux_mask_load,
  input  wire logic                 discordance_trip_brk1,
  input  wire logic                 discordance_trip_brk2,
  input  wire logic                 reclose_active_brk1,
  input  wire logic                 reclose_active_brk2,
  input  wire logic                 ext_pole_a_trip_in,
  input  wire logic                 ext_pole_b_trip_in,
  input  wire logic                 ext_pole_c_trip_in,
  input  wire logic                 ext_three_phase_trip_in,
  input  wire logic                 programmable_trip_in,
  input  wire logic                 global_trip_block_in,
  input  wire logic                 pole_a_block_in,
  input  wire logic                 pole_b_block_in,
  input  wire logic                 pole_c_block_in,
  input  wire logic                 fault_detector_active,
  input  wire logic                 three_phase_ready,
  input  wire logic                 fault_phase_a_in,
  input  wire logic                 fault_phase_b_in,
  input  wire logic                 fault_phase_c_in,
  input  wire logic                 pole_a_current_zero,
  input  wire logic                 pole_b_current_zero,
  input  wire logic                 pole_c_current_zero,
  output logic                      trip_command_out,
  output logic                      pole_a_trip_out,
  output logic                      pole_b_trip_out,
  output logic                      pole_c_trip_out,
  output logic                      trip_out,
  output logic                      three_phase_trip_out,
  output logic                      discordance_trip_combined,
  output logic                      reclose_active_combined,
  output logic [AUX_W-1:0]          aux_mask_out
);

  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [AUX_W-1:0]  mask_q;
  logic [AUX_W-1:0]  mask_d;
  logic              trip_cmd_q;
  logic              trip_cmd_d;
  logic              three_phase_q;
  logic              three_phase_d;
  logic [2:0]        latch_w;
  logic [2:0]        pole_trip_w;

  wire [SYNC_W-1:0]    raw_w;
  wire [AUX_EXT_W-1:0] aux_s;
  wire                 disc_comb_s;
  wire [AUX_W-1:0]     aux_all_w;
  wire [AUX_W-1:0]     masked_w;
  wire [2:0]           ext_pole_s;
  wire [2:0]           pole_blk_s;
  wire [2:0]           fault_ph_s;
  wire [2:0]           cur_zero_s;
  wire                 ext3_s;
  wire                 prog_s;
  wire                 gblk_s;
  wire                 det_s;
  wire                 ready_s;
  wire                 det_src_w;
  wire                 ex_src_w;
  wire                 new_src_w;
  wire                 src_live_w;
  wire                 prior_w;
  wire                 det_clear_w;

  //////////////////////////////////////////////////////////////////////////
  // input synchroniser
  // every trip input comes from outside this clock, so all of them pass
  // two flops; the cost is two cycles of added trip latency
  assign raw_w = {pole_c_current_zero, pole_b_current_zero, pole_a_current_zero,
                  fault_phase_c_in, fault_phase_b_in, fault_phase_a_in,
                  three_phase_ready, fault_detector_active,
                  pole_c_block_in, pole_b_block_in, pole_a_block_in,
                  global_trip_block_in, programmable_trip_in,
                  ext_three_phase_trip_in,
                  ext_pole_c_trip_in, ext_pole_b_trip_in, ext_pole_a_trip_in,
                  reclose_active_brk2, reclose_active_brk1,
                  discordance_trip_brk2, discordance_trip_brk1,
                  aux_trip_in};

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= raw_w;
      sync2_q <= sync1_q;
    end
  end

  // named views of the second synchroniser stage
  assign aux_s      = sync2_q[AUX_EXT_W-1:0];
  assign ext_pole_s = sync2_q[SB_EXT_LSB+2:SB_EXT_LSB];
  assign pole_blk_s = sync2_q[SB_BLK_LSB+2:SB_BLK_LSB];
  assign fault_ph_s = sync2_q[SB_FPH_LSB+2:SB_FPH_LSB];
  assign cur_zero_s = sync2_q[SB_CZ_LSB+2:SB_CZ_LSB];
  assign ext3_s     = sync2_q[SB_EXT_3PH];
  assign prog_s     = sync2_q[SB_PROG];
  assign gblk_s     = sync2_q[SB_GBLK];
  assign det_s      = sync2_q[SB_DET];
  assign ready_s    = sync2_q[SB_READY];

  //////////////////////////////////////////////////////////////////////////
  // auxiliary unit mask
  // entries reset to no; a load pulse takes the whole setting at once so
  // a half-written mask never steers the trip logic
  assign mask_d = aux_mask_load ? aux_mask_in : mask_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      mask_q <= MASK_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // trip command generation
  // two breaker discordance trips feed the single discordance entry
  assign disc_comb_s = sync2_q[SB_DISC1] | sync2_q[SB_DISC2];
  assign aux_all_w   = {disc_comb_s, aux_s};
  assign masked_w    = aux_all_w & mask_q;
  // sources that need the fault detector
  assign det_src_w   = (|(masked_w & ~DET_EXEMPT)) | (|ext_pole_s);
  // sources exempt from the fault detector
  assign ex_src_w    = (|(masked_w & DET_EXEMPT)) | ext3_s | prog_s;
  assign new_src_w   = (det_src_w & det_s) | ex_src_w;
  assign src_live_w  = det_src_w | ex_src_w;
  assign prior_w     = |latch_w;
  assign trip_cmd_d  = ~gblk_s & (new_src_w | prior_w);
  // programmable and external three-phase trips never go single-pole
  assign three_phase_d = ready_s | ext3_s | prog_s;
  assign det_clear_w   = ~det_s | gblk_s;

  always_ff @(posedge clk) begin
    if (reset) begin
      trip_cmd_q    <= 1'b0;
      three_phase_q <= 1'b0;
    end else begin
      trip_cmd_q    <= trip_cmd_d;
      three_phase_q <= three_phase_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per-pole sub-logics, all driven by the one shared command
  pole_trip_logic u_pole_a (
    .clk          (clk),
    .reset        (reset),
    .trip_cmd     (trip_cmd_q),
    .three_phase  (three_phase_q),
    .phase_sel    (fault_ph_s[0]),
    .pole_block   (pole_blk_s[0]),
    .ext_pole     (ext_pole_s[0]),
    .src_live     (src_live_w),
    .det_clear    (det_clear_w),
    .current_zero (cur_zero_s[0]),
    .latch_q      (latch_w[0]),
    .pole_trip_q  (pole_trip_w[0])
  );

  pole_trip_logic u_pole_b (
    .clk          (clk),
    .reset        (reset),
    .trip_cmd     (trip_cmd_q),
    .three_phase  (three_phase_q),
    .phase_sel    (fault_ph_s[1]),
    .pole_block   (pole_blk_s[1]),
    .ext_pole     (ext_pole_s[1]),
    .src_live     (src_live_w),
    .det_clear    (det_clear_w),
    .current_zero (cur_zero_s[1]),
    .latch_q      (latch_w[1]),
    .pole_trip_q  (pole_trip_w[1])
  );

  pole_trip_logic u_pole_c (
    .clk          (clk),
    .reset        (reset),
    .trip_cmd     (trip_cmd_q),
    .three_phase  (three_phase_q),
    .phase_sel    (fault_ph_s[2]),
    .pole_block   (pole_blk_s[2]),
    .ext_pole     (ext_pole_s[2]),
    .src_live     (src_live_w),
    .det_clear    (det_clear_w),
    .current_zero (cur_zero_s[2]),
    .latch_q      (latch_w[2]),
    .pole_trip_q  (pole_trip_w[2])
  );

  //////////////////////////////////////////////////////////////////////////
  // breaker level outputs
  breaker_trip_logic u_breaker (
    .clk                (clk),
    .reset              (reset),
    .pole_trip          (pole_trip_w),
    .three_phase        (three_phase_q),
    .disc_brk1          (sync2_q[SB_DISC1]),
    .disc_brk2          (sync2_q[SB_DISC2]),
    .rec_brk1           (sync2_q[SB_REC1]),
    .rec_brk2           (sync2_q[SB_REC2]),
    .trip_q             (trip_out),
    .three_phase_trip_q (three_phase_trip_out),
    .disc_combined_q    (discordance_trip_combined),
    .rec_combined_q     (reclose_active_combined)
  );

  // pole flops drive the pole outputs directly
  assign pole_a_trip_out  = pole_trip_w[0];
  assign pole_b_trip_out  = pole_trip_w[1];
  assign pole_c_trip_out  = pole_trip_w[2];
  assign trip_command_out = trip_cmd_q;
  assign aux_mask_out     = mask_q;

  //////////////////////////////////////////////////////////////////////////
  // checks
  sequence gblk_held_s;
    global_trip_block_in [*3];
  endsequence

  sequence ext_a_held_s;
    ext_pole_a_trip_in [*3];
  endsequence

  sequence prog_held_s;
    (programmable_trip_in && !global_trip_block_in) [*3];
  endsequence

  // no external input, no command and no latch behind pole a
  sequence ext_a_off_s;
    (!ext_pole_a_trip_in && !trip_command_out && !latch_w[0]) [*3];
  endsequence

  chk_global_block_cmd: assert property (@(posedge clk) disable iff (reset)
    gblk_held_s |=> !trip_command_out)
    else $error("trip command present under global block");

  chk_ext_pole_direct: assert property (@(posedge clk) disable iff (reset)
    ext_a_held_s |=> pole_a_trip_out)
    else $error("external pole a trip not passed through");

  chk_prog_three_phase: assert property (@(posedge clk) disable iff (reset)
    prog_held_s |=> trip_command_out ##1 three_phase_q)
    else $error("programmable trip gave no three phase command");

  // a latch that outlived a global block brings the command back on its own,
  // which is a sustained trip and not a new one
  chk_cmd_has_source: assert property (@(posedge clk) disable iff (reset)
    ($rose(trip_cmd_q) && !$past(prior_w)) |-> $past(new_src_w))
    else $error("trip command rose without a source");

  chk_detector_required: assert property (@(posedge clk) disable iff (reset)
    ($rose(trip_cmd_q) && !$past(ex_src_w) && !$past(prior_w)) |-> $past(det_s))
    else $error("trip without fault detector from non exempt unit");

  chk_cmd_sustain: assert property (@(posedge clk) disable iff (reset)
    (prior_w && !gblk_s) |=> trip_cmd_q)
    else $error("existing trip failed to sustain command");

  chk_mask_default: assert property (@(posedge clk)
    reset |=> (mask_q == MASK_RESET))
    else $error("mask not cleared by reset");

  chk_mask_blocks: assert property (@(posedge clk) disable iff (reset)
    (mask_q == MASK_RESET && !(|ext_pole_s) && !ext3_s && !prog_s
     && !prior_w) |=> !trip_cmd_q)
    else $error("masked units produced a command");

  // the external pole path must not leave a pole tripped once it drops
  chk_ext_pole_release: assert property (@(posedge clk) disable iff (reset)
    ext_a_off_s |=> !pole_a_trip_out)
    else $error("pole a trip stayed after external input dropped");

  // a three-phase command sets every unblocked pole together
  chk_three_phase_poles: assert property (@(posedge clk) disable iff (reset)
    (trip_cmd_q && three_phase_q && !(|pole_blk_s)) |=> (&latch_w))
    else $error("three phase command left a pole untripped");

endmodule : single_three_phase_trip_logic

// ### verif/breaker_pole_model.sv
`timescale 1ns/10ps
module breaker_pole_model #(
  parameter int OPEN_DLY = 3
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [2:0] pole_trip,
  output logic      [2:0] current_zero
);
  logic [3:0] open_cnt_q [3];

  ////////////////////////////////////////////////////////////////////////////
  // a pole opens OPEN_DLY cycles after its trip; a dropped trip recloses at once,
  // which ignores arcing but keeps the runs short
  always_ff @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (reset || !pole_trip[i]) begin
        open_cnt_q[i] <= 4'h0;
      end else if (open_cnt_q[i] != 4'(OPEN_DLY)) begin
        open_cnt_q[i] <= open_cnt_q[i] + 4'h1;
      end
    end
  end

  // current reads zero only once the commanded pole has opened
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      current_zero[i] = (open_cnt_q[i] == 4'(OPEN_DLY));
    end
  end
endmodule : breaker_pole_model

// ### verif/tb_single_three_phase_trip_logic.sv
`timescale 1ns/10ps
module tb_single_three_phase_trip_logic;
  import trip_logic_pkg::*;
  typedef struct packed {
    logic [5:0] aux; logic msk; logic det; logic gblk; logic ext3; logic prog; logic rdy;
    logic [2:0] fph; logic [2:0] blk; logic disc2; logic cmd; logic [2:0] pol;
  } row_s;
  // unit 63 means no aux unit; unit 43 is the discordance entry fed by breaker 2
  row_s rows [11] = '{
    '{6'h00, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 3'h1, 3'h0, 1'h0, 1'h1, 3'h1},
    '{6'h06, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 3'h1, 3'h0, 1'h0, 1'h0, 3'h0},
    '{6'h06, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 3'h2, 3'h0, 1'h0, 1'h1, 3'h2},
    '{6'h06, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 3'h2, 3'h0, 1'h0, 1'h0, 3'h0},
    '{6'h00, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 3'h1, 3'h0, 1'h0, 1'h0, 3'h0},
    '{6'h3F, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 3'h0, 3'h0, 1'h0, 1'h1, 3'h7},
    '{6'h3F, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 3'h0, 3'h0, 1'h0, 1'h1, 3'h7},
    '{6'h09, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 3'h1, 3'h0, 1'h0, 1'h1, 3'h7},
    '{6'h1C, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 3'h4, 3'h0, 1'h0, 1'h1, 3'h4},
    '{6'h2B, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 3'h1, 3'h0, 1'h1, 1'h1, 3'h1},
    '{6'h06, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 3'h1, 3'h1, 1'h0, 1'h1, 3'h0}
  };
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [AUX_EXT_W-1:0] aux_trip_in = '0;
  logic [AUX_W-1:0] aux_mask_in = '0;
  logic [AUX_W-1:0] aux_mask_out;
  logic aux_mask_load = 1'b0;
  logic disc1 = 1'b0, disc2 = 1'b0, rec1 = 1'b0, rec2 = 1'b0, ext3 = 1'b0, prog = 1'b0;
  logic [2:0] ext_p = '0, blk = '0, fph = '0;
  wire  [2:0] czero, pol;
  logic gblk = 1'b0, det = 1'b0, rdy = 1'b0;
  logic cmd, trip_out, tp_out, disc_out, rec_out;
  int mismatches = 0;
  int compares = 0;

  ////////////////////////////////////////////////////////////////////////////
  // clock, design and breaker model
  always #20 clk = ~clk;

  single_three_phase_trip_logic dut_u (
    .clk(clk), .reset(reset), .aux_trip_in(aux_trip_in), .aux_mask_in(aux_mask_in),
    .aux_mask_load(aux_mask_load), .discordance_trip_brk1(disc1),
    .discordance_trip_brk2(disc2), .reclose_active_brk1(rec1), .reclose_active_brk2(rec2),
    .ext_pole_a_trip_in(ext_p[0]), .ext_pole_b_trip_in(ext_p[1]),
    .ext_pole_c_trip_in(ext_p[2]), .ext_three_phase_trip_in(ext3),
    .programmable_trip_in(prog), .global_trip_block_in(gblk), .pole_a_block_in(blk[0]),
    .pole_b_block_in(blk[1]), .pole_c_block_in(blk[2]), .fault_detector_active(det),
    .three_phase_ready(rdy), .fault_phase_a_in(fph[0]), .fault_phase_b_in(fph[1]),
    .fault_phase_c_in(fph[2]), .pole_a_current_zero(czero[0]),
    .pole_b_current_zero(czero[1]), .pole_c_current_zero(czero[2]),
    .trip_command_out(cmd), .pole_a_trip_out(pol[0]), .pole_b_trip_out(pol[1]),
    .pole_c_trip_out(pol[2]), .trip_out(trip_out), .three_phase_trip_out(tp_out),
    .discordance_trip_combined(disc_out), .reclose_active_combined(rec_out),
    .aux_mask_out(aux_mask_out)
  );

  breaker_pole_model #(.OPEN_DLY(3)) brk_u (
    .clk(clk), .reset(reset), .pole_trip(pol), .current_zero(czero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // comparison and timing helpers
  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_vec(input string what, input logic [AUX_W-1:0] exp,
                         input logic [AUX_W-1:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_vec

  // settle past the edge so the design's own updates have landed
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cycles

  task automatic pulse_reset(input int n);
    @(posedge clk);
    reset <= 1'b1;
    {aux_trip_in, ext_p, blk, fph, disc1, disc2, rec1, rec2} <= '0;
    {ext3, prog, gblk, det, rdy} <= '0;
    repeat (n) @(posedge clk);
    reset <= 1'b0;
  endtask : pulse_reset

  // the mask strobe is one cycle wide and takes effect on the next edge
  task automatic load_mask(input logic [AUX_W-1:0] m);
    @(posedge clk);
    aux_mask_in <= m;
    aux_mask_load <= 1'b1;
    @(posedge clk);
    aux_mask_load <= 1'b0;
  endtask : load_mask

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    pulse_reset(10);
    cycles(1);
    chk_vec("mask_reset", MASK_RESET, aux_mask_out);
    chk_bit("cmd_reset", 1'b0, cmd);
    chk_bit("trip_reset", 1'b0, trip_out);
    load_mask(44'hA5A_5A5A_5A5A);
    cycles(1);
    chk_vec("mask_load", 44'hA5A_5A5A_5A5A, aux_mask_out);
    foreach (rows[i]) begin
      pulse_reset(2);
      // one unit is left unmasked whenever an aux unit is meant to trip
      load_mask(rows[i].msk ? (44'h1 << rows[i].aux) : '0);
      @(posedge clk);
      aux_trip_in <= (rows[i].aux < 6'h2B) ? (43'h1 << rows[i].aux) : '0;
      {det, gblk, ext3, prog, rdy} <= {rows[i].det, rows[i].gblk, rows[i].ext3,
                                       rows[i].prog, rows[i].rdy};
      {fph, blk, disc2} <= {rows[i].fph, rows[i].blk, rows[i].disc2};
      cycles(8);
      chk_bit("trip_command_out", rows[i].cmd, cmd);
      chk_vec("pole_trips", 44'(rows[i].pol), 44'(pol));
      chk_bit("trip_out", |rows[i].pol, trip_out);
      chk_bit("three_phase_trip_out", (|rows[i].pol) &
              (rows[i].rdy | rows[i].ext3 | rows[i].prog), tp_out);
    end
    // latched pole trip outlives its source until all release terms hold
    pulse_reset(2);
    load_mask(44'h1);
    @(posedge clk);
    {aux_trip_in[0], det, fph[0]} <= 3'h7;
    cycles(8);
    @(posedge clk);
    aux_trip_in[0] <= 1'b0;
    cycles(8);
    chk_bit("cmd_sustained", 1'b1, cmd);
    chk_bit("pole_a_latched", 1'b1, pol[0]);
    @(posedge clk);
    det <= 1'b0;
    cycles(8);
    chk_bit("pole_a_no_block", 1'b1, pol[0]);
    @(posedge clk);
    blk[0] <= 1'b1;
    cycles(8);
    chk_bit("pole_a_released", 1'b0, pol[0]);
    chk_bit("trip_out_released", 1'b0, trip_out);
    // external pole inputs trip their own poles, pole b even while blocked
    pulse_reset(2);
    @(posedge clk);
    ext_p <= 3'h3;
    blk <= 3'h2;
    cycles(5);
    chk_vec("ext_poles_ab", 44'h3, 44'(pol));
    @(posedge clk);
    ext_p <= 3'h0;
    cycles(5);
    chk_bit("ext_pole_b_drop", 1'b0, pol[1]);
    chk_bit("ext_pole_a_drop", 1'b0, pol[0]);
    // combined discordance and reclose flags, one breaker each
    @(posedge clk);
    disc1 <= 1'b1;
    rec2 <= 1'b1;
    cycles(5);
    chk_bit("disc_combined", 1'b1, disc_out);
    chk_bit("rec_combined", 1'b1, rec_out);
    @(posedge clk);
    {disc1, rec2, rec1} <= 3'h1;
    cycles(5);
    chk_bit("disc_none", 1'b0, disc_out);
    chk_bit("rec_brk1", 1'b1, rec_out);
    // reset in mid-run clears every output while a trip source still stands
    @(posedge clk);
    ext3 <= 1'b1;
    blk <= 3'h0;
    cycles(8);
    chk_vec("ext3_all_poles", 44'h7, 44'(pol));
    chk_bit("ext3_three_phase", 1'b1, tp_out);
    @(posedge clk);
    reset <= 1'b1;
    cycles(2);
    chk_vec("pole_trips_mid_reset", 44'h0, 44'(pol));
    chk_bit("cmd_mid_reset", 1'b0, cmd);
    chk_bit("trip_mid_reset", 1'b0, trip_out);
    report_and_stop();
  end
endmodule : tb_single_three_phase_trip_logic
